// ### common/sots_pkg.sv
// Shared constants and types for the output tagging and scrambling block
package sots_pkg;
  localparam int WORD_W = 21;
  localparam int DATA_W = 16;
  localparam int TAG_W = 5;
  localparam int SEL_W = 4;
  localparam int NUM_SLOTS = 7;
  localparam int LOW_PAIR_W = 7;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SCR_CTRL = 8'h05;
  localparam logic [7:0] IDX_OUT_OPT = 8'h08;
  localparam logic [7:0] IDX_SLOT_LO = 8'h10;
  localparam logic [7:0] IDX_SLOT_HI = 8'h11;
  localparam logic [7:0] IDX_KEY_STAT = 8'h12;
  localparam int SCR_MODE_LSB = 3;
  localparam int SCR_SUB_LSB = 1;
  localparam int OPT_FLEX_BIT = 0;
  localparam int OPT_PAIR_DIS_BIT = 1;
  localparam int OPT_LAT_OFF_BIT = 2;
  localparam logic [7:0] SCR_CTRL_RST = 8'h00;
  localparam logic [7:0] OUT_OPT_RST = 8'h00;
  localparam logic [15:0] SLOT_LO_RST = 16'h0000;
  localparam logic [11:0] SLOT_HI_RST = 12'h000;
  localparam logic [20:0] KEY_PRELOAD = 21'h0_0001;
  // Analog chain latency in serializer cycles
  localparam int TAG_LAT_DEF = 8;
  localparam int KEY_LAT_DEF = 8;
  localparam logic [3:0] SEL_KEEP = 4'h0;
  localparam logic [3:0] SEL_LEG4 = 4'h5;
  localparam logic [3:0] SEL_RED = 4'h6;
  localparam logic [3:0] SEL_GREEN = 4'h7;
  localparam logic [3:0] SEL_BLUE = 4'h8;
  localparam logic [3:0] SEL_PARITY = 4'h9;
  localparam logic [3:0] SEL_PING = 4'hA;
  localparam logic [3:0] SEL_LINE_LO = 4'hB;
  localparam logic [3:0] SEL_LINE_HI = 4'hC;
  localparam logic [3:0] SEL_BLACK = 4'hD;
  localparam logic [3:0] SEL_WHITE = 4'hE;
  localparam logic [3:0] SEL_CLAMP = 4'hF;
  localparam logic [4:0] K_SUB00 = 5'h00;
  localparam logic [4:0] K_SUB01 = 5'h05;
  localparam logic [4:0] K_SUB01_NARROW = 5'h07;
  localparam logic [4:0] K_SUB10 = 5'h10;
  localparam logic [4:0] K_SUB11 = 5'h14;
  // Word bit of each tag slot: five tag bits, then third and fourth data bits
  localparam logic [NUM_SLOTS-1:0][4:0] SLOT_POS = {5'h08, 5'h07, 5'h04, 5'h03,
    5'h02, 5'h01, 5'h00};
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_FULL = 2'b01,
    MODE_ONEKEY = 2'b10,
    MODE_LSBKEY = 2'b11
  } sots_mode_e;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_WAIT = 3'b010,
    SEQ_RUN = 3'b100
  } sots_seq_e;
  typedef struct packed {
    logic [TAG_W-1:0] control_tag_bits;
    logic red;
    logic green;
    logic blue;
    logic ping;
    logic [1:0] line_idx;
    logic black_loop;
    logic white_loop;
    logic input_clamp_switch;
  } sots_tag_info_s;
endpackage

// ### verilog/sots_link_sync.sv
// Three-stage synchroniser and rising-edge finder for the serializer clock
`timescale 1ns/100ps
`default_nettype none
module sots_link_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise_ff
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Level moves only when the two late stages agree
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
    end
    else
    begin
      if (s2_ff == s3_ff)
      begin
        level_ff <= s3_ff;
      end
      rise_ff <= (s2_ff == s3_ff) && s3_ff && !level_ff;
    end
  end
endmodule
`default_nettype wire

// ### verilog/sots_key_gen.sv
// Shift-register key generator with serial and 21-step parallel advance
`timescale 1ns/100ps
`default_nettype none
module sots_key_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic parallel,
  output logic [20:0] state_ff
);
  function automatic logic [20:0] shift1(input logic [20:0] s);
    shift1 = {s[0] ^ s[2], s[20:1]};
  endfunction

  function automatic logic [20:0] shift21(input logic [20:0] s);
    logic [20:0] t;
    t = s;
    for (int i = 0; i < 21; i++)
    begin
      t = shift1(t);
    end
    shift21 = t;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= sots_pkg::KEY_PRELOAD;
    end
    else if (load)
    begin
      state_ff <= sots_pkg::KEY_PRELOAD; // [RULE23]
    end
    else if (step)
    begin
      state_ff <= parallel ? shift21(state_ff) : shift1(state_ff); // [RULE13] [RULE14] [RULE15]
    end
  end
endmodule
`default_nettype wire

// ### verilog/sots_top.sv
// Output word tagging, parity and scrambling behind an AHB-Lite register slave
//
// Notes on behaviour
// RULE1: Slot selector 0000 keeps original bit; 0001-0101 give legacy tag bits 0-4.
// RULE2: Selectors 0110/0111/1000 give red, green, blue pixel flags.
// RULE3: Selector 1001 gives parity, over 21 bits or 14 with low pair off.
// RULE4: Selector 1010 is high for ping pixels, low for pong.
// RULE5: Selectors 1011/1100 give low and high bits of line index.
// RULE6: Selectors 1101/1110/1111 give black loop, white loop, clamp flags.
// RULE7: Lowest data pair can be disabled, leaving a 14-bit link.
// RULE8: Third and fourth data bits may carry selected tags too.
// RULE9: Positions carrying parity are left out of the parity sum.
// RULE10: In one-bit key mode the key position is left out of parity.
// RULE11: Ones across counted bits, parity included, are even.
// RULE12: Tags are delayed by chain latency unless option bit 2 is set.
// RULE13: Key is a 21-bit right-shift maximal LFSR preloaded with one.
// RULE14: Serial key form shifts once per serializer cycle.
// RULE15: Parallel key form advances 21 shifts per serializer cycle.
// RULE16: Mode at bits 4:3, submode at bits 2:1 of scrambler control.
// RULE17: Mode 00 passes the word unchanged.
// RULE18: Mode 01 submodes: word^serial, serial, word^parallel, parallel key.
// RULE19: Mode 10 clears bit k, XORs all with key bit 0.
// RULE20: k is 0, 5 (7 when pair off), 16 or 20 by submode.
// RULE21: Mode 11 XORs other bits with word bit k, k unchanged.
// RULE22: Key starts a latency after line start falls, advances every cycle.
// RULE23: Key register reloads its preload at each sequence start.
// RULE24: Receiver runs the same key generator and inverts the XOR.
`timescale 1ns/100ps
`default_nettype none
module sots_top #(
  parameter int TAG_LAT = sots_pkg::TAG_LAT_DEF,
  parameter int KEY_LAT = sots_pkg::KEY_LAT_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata_ff,
  output logic hreadyout_ff,
  output logic hresp_ff,
  input wire logic serializer_clock,
  input wire logic line_start,
  input wire logic [15:0] pixel_data,
  input wire sots_pkg::sots_tag_info_s tag_info,
  output logic [20:0] out_word_ff,
  output logic word_strobe_ff
);
  logic tick;
  logic pend_ff;
  logic pend_wr_ff;
  logic [7:0] pend_idx_ff;
  logic [7:0] scr_ctrl_ff;
  logic [7:0] out_opt_ff;
  logic [15:0] slot_lo_ff;
  logic [11:0] slot_hi_ff;
  logic [31:0] nxt_rdata;
  sots_pkg::sots_tag_info_s tag_pipe_ff [TAG_LAT];
  sots_pkg::sots_tag_info_s tag_now;
  sots_pkg::sots_seq_e seq_ff;
  logic [15:0] seq_cnt_ff;
  logic line_start_d_ff;
  logic [20:0] key;
  logic key_load;
  logic [20:0] sub_word;
  logic [20:0] par_mask;
  logic [20:0] count_mask;
  logic parity;
  logic [4:0] kpos;
  logic [20:0] nxt_out;
  logic [27:0] slot_sel;
  logic flex_en;
  logic pair_dis;
  sots_pkg::sots_mode_e mode;
  logic [1:0] submode;
  logic key_par;

  assign flex_en = out_opt_ff[sots_pkg::OPT_FLEX_BIT];
  assign pair_dis = out_opt_ff[sots_pkg::OPT_PAIR_DIS_BIT];
  assign mode = sots_pkg::sots_mode_e'(scr_ctrl_ff[sots_pkg::SCR_MODE_LSB +: 2]); // [RULE16]
  assign submode = scr_ctrl_ff[sots_pkg::SCR_SUB_LSB +: 2]; // [RULE16]
  assign slot_sel = {slot_hi_ff, slot_lo_ff};
  // One-bit key mode takes bit zero of the serial key, whatever the submode
  assign key_par = (mode == sots_pkg::MODE_FULL) && submode[1]; // [RULE15] [RULE19]

  sots_link_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(serializer_clock),
    .rise_ff(tick)
  );

  // One wait state on every transfer keeps hrdata a clean flop output
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_ff <= 1'b0;
      pend_wr_ff <= 1'b0;
      pend_idx_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
    else if (pend_ff)
    begin
      pend_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
    end
    else if (hsel && htrans[1] && hready)
    begin
      pend_ff <= 1'b1;
      pend_wr_ff <= hwrite;
      pend_idx_ff <= haddr[9:2];
      hreadyout_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scr_ctrl_ff <= sots_pkg::SCR_CTRL_RST;
      out_opt_ff <= sots_pkg::OUT_OPT_RST;
      slot_lo_ff <= sots_pkg::SLOT_LO_RST;
      slot_hi_ff <= sots_pkg::SLOT_HI_RST;
    end
    else if (pend_ff && pend_wr_ff)
    begin
      case (pend_idx_ff)
        sots_pkg::IDX_SCR_CTRL: scr_ctrl_ff <= hwdata[7:0];
        sots_pkg::IDX_OUT_OPT: out_opt_ff <= hwdata[7:0];
        sots_pkg::IDX_SLOT_LO: slot_lo_ff <= hwdata[15:0];
        sots_pkg::IDX_SLOT_HI: slot_hi_ff <= hwdata[11:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (pend_idx_ff)
      sots_pkg::IDX_SCR_CTRL: nxt_rdata = {24'h00_0000, scr_ctrl_ff};
      sots_pkg::IDX_OUT_OPT: nxt_rdata = {24'h00_0000, out_opt_ff};
      sots_pkg::IDX_SLOT_LO: nxt_rdata = {16'h0000, slot_lo_ff};
      sots_pkg::IDX_SLOT_HI: nxt_rdata = {20'h0_0000, slot_hi_ff};
      sots_pkg::IDX_KEY_STAT: nxt_rdata = {8'h00, seq_ff, key};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata_ff <= 32'h0000_0000;
    end
    else if (pend_ff && !pend_wr_ff)
    begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // Tag delay line, one stage per serializer cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < TAG_LAT; i++)
      begin
        tag_pipe_ff[i] <= '0;
      end
    end
    else if (tick)
    begin
      tag_pipe_ff[0] <= tag_info;
      for (int i = 1; i < TAG_LAT; i++)
      begin
        tag_pipe_ff[i] <= tag_pipe_ff[i-1];
      end
    end
  end

  assign tag_now = out_opt_ff[sots_pkg::OPT_LAT_OFF_BIT] ? tag_info
    : tag_pipe_ff[TAG_LAT-1]; // [RULE12]

  // Key sequencer: wait out the chain latency after line start falls
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_ff <= sots_pkg::SEQ_IDLE;
      seq_cnt_ff <= 16'h0000;
      line_start_d_ff <= 1'b0;
    end
    else if (tick)
    begin
      line_start_d_ff <= line_start;
      if (line_start_d_ff && !line_start)
      begin
        seq_ff <= sots_pkg::SEQ_WAIT; // [RULE22]
        seq_cnt_ff <= 16'(KEY_LAT);
      end
      else
      begin
        case (seq_ff)
          sots_pkg::SEQ_IDLE: seq_ff <= sots_pkg::SEQ_IDLE;
          sots_pkg::SEQ_WAIT:
          begin
            if (seq_cnt_ff == 16'h0000)
            begin
              seq_ff <= sots_pkg::SEQ_RUN;
            end
            else
            begin
              seq_cnt_ff <= seq_cnt_ff - 16'h0001;
            end
          end
          sots_pkg::SEQ_RUN: seq_ff <= sots_pkg::SEQ_RUN;
          default: seq_ff <= sots_pkg::SEQ_IDLE;
        endcase
      end
    end
  end

  assign key_load = tick && (seq_ff == sots_pkg::SEQ_WAIT) && (seq_cnt_ff == 16'h0000)
    && !(line_start_d_ff && !line_start); // [RULE23]

  sots_key_gen u_key (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(key_load),
    .step(tick && (seq_ff == sots_pkg::SEQ_RUN)), // [RULE22]
    .parallel(key_par), // [RULE15] [RULE19]
    .state_ff(key)
  );

  function automatic logic tag_bit(input logic [3:0] sel, input sots_pkg::sots_tag_info_s t);
    case (sel)
      sots_pkg::SEL_RED: tag_bit = t.red; // [RULE2]
      sots_pkg::SEL_GREEN: tag_bit = t.green; // [RULE2]
      sots_pkg::SEL_BLUE: tag_bit = t.blue; // [RULE2]
      sots_pkg::SEL_PING: tag_bit = t.ping; // [RULE4]
      sots_pkg::SEL_LINE_LO: tag_bit = t.line_idx[0]; // [RULE5]
      sots_pkg::SEL_LINE_HI: tag_bit = t.line_idx[1]; // [RULE5]
      sots_pkg::SEL_BLACK: tag_bit = t.black_loop; // [RULE6]
      sots_pkg::SEL_WHITE: tag_bit = t.white_loop; // [RULE6]
      sots_pkg::SEL_CLAMP: tag_bit = t.input_clamp_switch; // [RULE6]
      default: tag_bit = (sel <= sots_pkg::SEL_LEG4) && (sel != sots_pkg::SEL_KEEP)
        ? t.control_tag_bits[3'(sel - 4'h1)] : 1'b0; // [RULE1]
    endcase
  endfunction

  always_comb
  begin
    case (submode)
      2'b00: kpos = sots_pkg::K_SUB00;
      2'b01: kpos = pair_dis ? sots_pkg::K_SUB01_NARROW : sots_pkg::K_SUB01;
      2'b10: kpos = sots_pkg::K_SUB10;
      default: kpos = sots_pkg::K_SUB11;
    endcase
  end // [RULE20]

  // Slot substitution; parity slots are filled after the sum is known
  always_comb
  begin
    logic [3:0] sel;
    sel = 4'h0;
    sub_word = {pixel_data, tag_now.control_tag_bits};
    par_mask = 21'h00_0000;
    for (int i = 0; i < sots_pkg::NUM_SLOTS; i++)
    begin
      sel = slot_sel[i*4 +: 4];
      if (flex_en && sel == sots_pkg::SEL_PARITY)
      begin
        par_mask[sots_pkg::SLOT_POS[i]] = 1'b1; // [RULE3]
      end
      else if (flex_en && sel != sots_pkg::SEL_KEEP)
      begin
        sub_word[sots_pkg::SLOT_POS[i]] = tag_bit(sel, tag_now); // [RULE1] [RULE8]
      end
    end
    if (pair_dis)
    begin
      sub_word[sots_pkg::LOW_PAIR_W-1:0] = 7'h00; // [RULE7]
    end
    count_mask = ~par_mask; // [RULE9]
    if (pair_dis)
    begin
      count_mask[sots_pkg::LOW_PAIR_W-1:0] = 7'h00; // [RULE3]
    end
    if (mode == sots_pkg::MODE_ONEKEY)
    begin
      count_mask[kpos] = 1'b0; // [RULE10]
    end
    parity = ^(sub_word & count_mask); // [RULE11]
    for (int b = 0; b < sots_pkg::WORD_W; b++)
    begin
      if (par_mask[b])
      begin
        sub_word[b] = parity;
      end
    end
  end

  always_comb
  begin
    logic [20:0] w;
    w = sub_word;
    case (mode)
      sots_pkg::MODE_OFF: nxt_out = sub_word; // [RULE17]
      sots_pkg::MODE_FULL: nxt_out = submode[0] ? key : (sub_word ^ key); // [RULE18]
      sots_pkg::MODE_ONEKEY:
      begin
        w[kpos] = 1'b0;
        nxt_out = w ^ {21{key[0]}}; // [RULE19]
      end
      sots_pkg::MODE_LSBKEY:
      begin
        nxt_out = sub_word ^ {21{sub_word[kpos]}};
        nxt_out[kpos] = sub_word[kpos]; // [RULE21]
      end
      default: nxt_out = sub_word;
    endcase
    if (pair_dis)
    begin
      nxt_out[sots_pkg::LOW_PAIR_W-1:0] = 7'h00; // [RULE7]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_word_ff <= 21'h00_0000;
      word_strobe_ff <= 1'b0;
    end
    else
    begin
      word_strobe_ff <= tick;
      if (tick)
      begin
        out_word_ff <= nxt_out;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  mode_off_pass_a: assert property (tick && mode == sots_pkg::MODE_OFF && !pair_dis // [RULE17]
    |=> out_word_ff == $past(sub_word)) else $error("mode 00 altered word");
  pair_zero_a: assert property (word_strobe_ff && $past(pair_dis) // [RULE7]
    |-> out_word_ff[6:0] == 7'h00) else $error("low pair not zero");
  even_parity_a: assert property (mode != sots_pkg::MODE_ONEKEY // [RULE11]
    |-> ^(sub_word & (count_mask | par_mask)) == 1'b0 || par_mask == 21'h00_0000)
    else $error("parity not even");
  key_step_a: assert property (tick && seq_ff == sots_pkg::SEQ_RUN && !key_par // [RULE14]
    && !key_load |=> key == {$past(key[0]) ^ $past(key[2]), $past(key[20:1])})
    else $error("serial key did not shift once");
  key_hold_a: assert property (!tick |=> key == $past(key)) // [RULE22]
    else $error("key moved without a cycle");
  key_load_a: assert property (key_load // [RULE23]
    |=> key == sots_pkg::KEY_PRELOAD && seq_ff == sots_pkg::SEQ_RUN)
    else $error("key not preloaded");
  onekey_pos_a: assert property (tick && mode == sots_pkg::MODE_ONEKEY && !pair_dis // [RULE19]
    |=> out_word_ff[$past(kpos)] == $past(key[0])) else $error("key bit not at k");
  lsb_keep_a: assert property (tick && mode == sots_pkg::MODE_LSBKEY && !pair_dis // [RULE21]
    |=> out_word_ff[$past(kpos)] == $past(sub_word[kpos]))
    else $error("key bit altered");
  full_key_a: assert property (tick && mode == sots_pkg::MODE_FULL && submode[0] // [RULE18]
    && !pair_dis |=> out_word_ff == $past(key)) else $error("key alone not sent");
  lat_off_a: assert property (out_opt_ff[sots_pkg::OPT_LAT_OFF_BIT] // [RULE12]
    |-> tag_now == tag_info) else $error("tags delayed with compensation off");
  bus_wait_a: assert property (hsel && htrans[1] && hready && hreadyout_ff
    |=> !hreadyout_ff ##1 hreadyout_ff) else $error("bus wait not one cycle");

  seq_start_c: cover property (key_load);
  par_slot_c: cover property (tick && par_mask != 21'h00_0000);
  onekey_c: cover property (tick && mode == sots_pkg::MODE_ONEKEY && pair_dis);
  parallel_c: cover property (tick && mode == sots_pkg::MODE_FULL && submode[1]);
endmodule
`default_nettype wire

// ### tb/sots_rx_model.sv
// Receiving end that regenerates the key stream and undoes the word scrambling
`timescale 1ns/100ps
`default_nettype none
module sots_rx_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [20:0] word,
  input wire logic strobe,
  input wire logic sync,
  input wire logic parallel,
  output logic [20:0] plain_ff
);
  logic [20:0] key_ff;
  logic [20:0] nxt_key;

  // Same generator as the sender, restarted on the shared start event
  always_comb
  begin
    nxt_key = key_ff;
    for (int i = 0; i < 21; i++)
    begin
      if (i == 0 || parallel)
        nxt_key = {nxt_key[0] ^ nxt_key[2], nxt_key[20:1]};
    end
    if (sync)
      nxt_key = sots_pkg::KEY_PRELOAD;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_ff <= sots_pkg::KEY_PRELOAD;
      plain_ff <= 21'h0_0000;
    end
    else if (strobe)
    begin
      key_ff <= nxt_key;
      plain_ff <= word ^ nxt_key;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the output tagging and scrambling block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int TLAT = 2;
  localparam int KLAT = 2;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic serializer_clock = 1'b0;
  logic line_start = 1'b0;
  logic [15:0] pixel_data = 16'h0000;
  sots_pkg::sots_tag_info_s tag_info = '0;
  logic [20:0] out_word_ff;
  logic word_strobe_ff;
  logic sync = 1'b0;
  logic par = 1'b0;
  logic [20:0] plain_ff;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int al;
  int k;
  logic [31:0] rd;
  logic [20:0] w;
  logic [20:0] e;
  logic [20:0] ws [16];
  logic [15:0] p;
  logic b;
  sots_pkg::sots_tag_info_s t;

  always #10 sys_clk = ~sys_clk;
  // Odd offset keeps the link clock out of phase with the system clock
  initial
  begin
    #3;
    forever #80 serializer_clock = ~serializer_clock;
  end

  sots_top #(.TAG_LAT(TLAT), .KEY_LAT(KLAT)) u_sots_top (.sys_clk(sys_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout_ff), .hrdata_ff(hrdata_ff),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .serializer_clock(serializer_clock),
    .line_start(line_start), .pixel_data(pixel_data), .tag_info(tag_info),
    .out_word_ff(out_word_ff), .word_strobe_ff(word_strobe_ff));

  sots_rx_model u_sots_rx_model (.sys_clk(sys_clk), .rst_n(rst_n), .word(out_word_ff),
    .strobe(word_strobe_ff), .sync(sync), .parallel(par), .plain_ff(plain_ff));

  task automatic end_sim;
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic chk21(input logic [20:0] g, input logic [20:0] x);
    chk32({11'h000, g}, {11'h000, x});
  endtask

  task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h00_0000, idx, 2'b00};
    hwrite <= wr_en;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hreadyout_ff !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout_ff !== 1'b1);
    rd = hrdata_ff;
    chk32({31'h0000_0000, hresp_ff}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] x);
    bus(1'b0, idx, 32'h0000_0000);
    chk32(rd, x);
  endtask

  // First word after a change may carry old inputs, so callers repeat; extra edge for receiver
  task automatic xfer(input logic [15:0] pd, input logic [13:0] ti, input logic ls,
    output logic [20:0] wo);
    pixel_data <= pd;
    tag_info <= ti;
    line_start <= ls;
    do @(posedge sys_clk); while (word_strobe_ff !== 1'b1);
    wo = out_word_ff;
    @(posedge sys_clk);
  endtask

  function automatic logic sel_val(input logic [3:0] s, input logic o,
    input sots_pkg::sots_tag_info_s q, input logic pa);
    logic [15:0] v;
    v = {q.input_clamp_switch, q.white_loop, q.black_loop, q.line_idx, q.ping, pa, q.blue,
      q.green, q.red, q.control_tag_bits, o};
    return v[s];
  endfunction

  function automatic logic [20:0] step(input logic [20:0] s, input int n);
    for (int i = 0; i < n; i++)
      s = {s[0] ^ s[2], s[20:1]};
    return s;
  endfunction

  // Line start pulse, then sixteen words; at >= 0 also checks the receiver's recovery
  task automatic run(input logic [7:0] c, input int at);
    logic [20:0] x;
    par <= c[2];
    wr(8'h05, {24'h00_0000, c});
    xfer(16'h0000, 14'h0000, 1'b1, x);
    xfer(16'h0000, 14'h0000, 1'b1, x);
    for (int j = 0; j < 16; j++)
    begin
      sync <= (j == at);
      xfer(16'(j) ^ 16'hA5C3, 14'h0000, 1'b0, ws[j]);
      if (at >= 0 && j >= at)
        chk21(plain_ff, {16'(j) ^ 16'hA5C3, 5'h00});
    end
    sync <= 1'b0;
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures++;
      end_sim();
    end
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk(8'h05, 32'h0000_0000);
    rdchk(8'h08, 32'h0000_0000);
    rdchk(8'h10, 32'h0000_0000);
    rdchk(8'h11, 32'h0000_0000);
    rdchk(8'h12, 32'h0020_0001);
    wr(8'h3F, 32'hFFFF_FFFF);
    rdchk(8'h3F, 32'h0000_0000);
    wr(8'h05, 32'h0000_001E);
    rdchk(8'h05, 32'h0000_001E);
    wr(8'h11, 32'h0000_0FFF);
    rdchk(8'h11, 32'h0000_0FFF);
    wr(8'h05, 32'h0000_0000);
    wr(8'h11, 32'h0000_0000);
    p = 16'h5A3C;
    t = 14'h0000;
    t.control_tag_bits = 5'h0A;
    repeat (4) xfer(p, t, 1'b0, w);
    t.control_tag_bits = 5'h15;
    xfer(p, t, 1'b0, w);
    chk21(w, {p, 5'h0A});
    repeat (4) xfer(p, t, 1'b0, w);
    chk21(w, {p, 5'h15});
    wr(8'h08, 32'h0000_0005);
    p = 16'hC3A5;
    for (int s = 0; s < 16; s++)
    begin
      for (int n = 0; n < 2; n++)
      begin
        wr(8'h10, 32'(s));
        t = n ? ~14'h2A5B : 14'h2A5B;
        xfer(p, t, 1'b0, w);
        xfer(p, t, 1'b0, w);
        e = {p, t.control_tag_bits};
        e[0] = sel_val(s[3:0], e[0], t, ^e[20:1]);
        chk21(w, e);
      end
    end
    wr(8'h10, 32'h0000_0000);
    wr(8'h11, 32'h0000_0F90);
    wr(8'h08, 32'h0000_0007);
    for (int n = 0; n < 2; n++)
    begin
      t = n ? ~14'h1C63 : 14'h1C63;
      xfer(p, t, 1'b0, w);
      xfer(p, t, 1'b0, w);
      b = t.input_clamp_switch;
      chk21(w, {p[15:4], b, ^{p[15:4], b}, 7'h00});
    end
    wr(8'h11, 32'h0000_0000);
    wr(8'h08, 32'h0000_0004);
    run(8'h0A, -1);
    al = -1;
    for (int j = 0; j < 15; j++)
      if (al < 0 && ws[j] === 21'h0_0001 && ws[j + 1] === 21'h10_0000)
        al = j;
    chk32(32'(al >= 0 && al <= KLAT + 3), 32'h0000_0001);
    if (al < 0)
      al = 0;
    e = 21'h0_0001;
    for (int j = al; j < 16 && j < al + 5; j++)
    begin
      chk21(ws[j], e);
      e = step(e, 1);
    end
    run(8'h0E, -1);
    e = 21'h0_0001;
    for (int j = al; j < 16 && j < al + 4; j++)
    begin
      chk21(ws[j], e);
      e = step(e, 21);
    end
    run(8'h08, al);
    run(8'h0C, al);
    p = 16'h9E47;
    t = 14'h1B6D;
    for (int m = 2; m < 4; m++)
    begin
      for (int c = 0; c < 5; c++)
      begin
        k = (c == 0) ? 0 : (c == 1) ? 5 : (c == 2) ? 16 : (c == 3) ? 20 : 7;
        wr(8'h08, (c == 4) ? 32'h0000_0006 : 32'h0000_0004);
        wr(8'h05, {27'h000_0000, m[1:0], (c == 4) ? 2'b01 : c[1:0], 1'b0});
        xfer(p, t, 1'b0, w);
        xfer(p, t, 1'b0, w);
        e = {p, t.control_tag_bits};
        b = (m == 3) ? e[k] : w[k];
        if (m == 2)
          e[k] = 1'b0;
        e = e ^ {21{b}};
        e[k] = b;
        if (c == 4)
          e[6:0] = 7'h00;
        chk21(w, e);
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
